// ==== rtl/gbcd_decoder.sv ====
// device-side bus command decoder
`include "gbcd_defs.svh"
`default_nettype none
module gbcd_decoder (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [4:0] primary_addr,
   input wire logic trigger_unaddressed,
   input wire logic lockout_released_by_local,
   input wire logic [7:0] dio_n_in,
   input wire logic atn_n_in,
   input wire logic ifc_n_in,
   input wire logic ren_n_in,
   input wire logic eoi_n_in,
   input wire logic dav_n_in,
   input wire logic service_req,
   input wire logic service_done,
   output logic ndac_n_out,
   output logic ndac_n_oe_n,
   output logic nrfd_n_out,
   output logic nrfd_n_oe_n,
   output logic srq_n_out,
   output logic srq_n_oe_n,
   output gbcd_pkg::gbcd_byte_s data_byte,
   output logic data_valid,
   output logic talker_active,
   output logic listener_active,
   output logic remote_mode,
   output logic lockout,
   output logic serial_poll,
   output logic device_clear,
   output logic trigger_pulse
);
   import gbcd_pkg::*;

   gbcd_mgmt_s mgmt;
   gbcd_hs_e hs_reg;
   logic [7:0] cmd;
   logic take;
   logic is_cmd;
   logic is_data;
   logic [7:0] my_listen;
   logic [7:0] my_talk;
   logic addressed_listen;
   logic local_hold;

   ////////////////////////////////////////////////////////////////////
   // line decode
   // true level is low
   assign mgmt.atn = ~atn_n_in;
   assign mgmt.ifc = ~ifc_n_in;
   assign mgmt.ren = ~ren_n_in;
   assign mgmt.eoi = ~eoi_n_in;
   assign cmd = ~dio_n_in;
   assign my_listen = `GBCD_LISTEN_BASE | {3'b000, primary_addr};
   assign my_talk = `GBCD_TALK_BASE | {3'b000, primary_addr};
   assign take = (hs_reg == GBCD_HS_TAKE);
   assign is_cmd = take && mgmt.atn;
   assign is_data = take && !mgmt.atn && listener_active;
   assign addressed_listen = listener_active;

   ////////////////////////////////////////////////////////////////////
   // acceptor handshake
   // not-accepted held until taken
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hs_reg <= GBCD_HS_IDLE;
      end
      else
      begin
         unique case (hs_reg)
            GBCD_HS_IDLE:
            begin
               if (!dav_n_in && (mgmt.atn || listener_active))
               begin
                  hs_reg <= GBCD_HS_TAKE;
               end
            end
            GBCD_HS_TAKE:
            begin
               hs_reg <= GBCD_HS_DONE;
            end
            GBCD_HS_DONE:
            begin
               if (dav_n_in)
               begin
                  hs_reg <= GBCD_HS_IDLE;
               end
            end
            default:
            begin
               hs_reg <= GBCD_HS_IDLE;
            end
         endcase
      end
   end

   // lines are open drain: out is always low, enable low pulls
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ndac_n_out <= 1'b0;
         ndac_n_oe_n <= 1'b0;
         nrfd_n_out <= 1'b0;
         nrfd_n_oe_n <= 1'b1;
      end
      else
      begin
         ndac_n_out <= 1'b0;
         nrfd_n_out <= 1'b0;
         ndac_n_oe_n <= (hs_reg == GBCD_HS_TAKE) || (hs_reg == GBCD_HS_DONE && !dav_n_in);
         nrfd_n_oe_n <= (hs_reg == GBCD_HS_IDLE) && dav_n_in;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // addressing
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         listener_active <= 1'b0;
         talker_active <= 1'b0;
      end
      else if (mgmt.ifc)
      begin
         listener_active <= 1'b0;
         talker_active <= 1'b0;
      end
      else if (is_cmd && ((cmd & `GBCD_GROUP_MASK) != `GBCD_SECONDARY_BASE))
      begin
         if ((cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_UNLISTEN)
         begin
            listener_active <= 1'b0;
         end
         else if ((cmd & `GBCD_BYTE_MASK) == my_listen)
         begin
            listener_active <= 1'b1;
         end
         if ((cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_UNTALK)
         begin
            talker_active <= 1'b0;
         end
         else if ((cmd & `GBCD_BYTE_MASK) == my_talk)
         begin
            talker_active <= 1'b1;
         end
         else if (((cmd & `GBCD_GROUP_MASK) == `GBCD_TALK_BASE))
         begin
            talker_active <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // remote, lockout, poll
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         remote_mode <= 1'b0;
         lockout <= 1'b0;
         local_hold <= 1'b0;
      end
      else if (!mgmt.ren)
      begin
         remote_mode <= 1'b0;
         lockout <= 1'b0;
         local_hold <= 1'b0;
      end
      else
      begin
         if (!remote_mode && !local_hold)
         begin
            remote_mode <= 1'b1;
         end
         // own listen address lifts go-to-local hold
         if (is_cmd && (cmd & `GBCD_BYTE_MASK) == my_listen)
         begin
            local_hold <= 1'b0;
         end
         if (is_cmd && (cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_LOCKOUT)
         begin
            lockout <= 1'b1;
         end
         if (is_cmd && addressed_listen && (cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_GO_LOCAL)
         begin
            remote_mode <= 1'b0;
            local_hold <= 1'b1;
            if (lockout_released_by_local)
            begin
               lockout <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         serial_poll <= 1'b0;
      end
      else if (is_cmd && (cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_POLL_ON)
      begin
         serial_poll <= 1'b1;
      end
      else if (is_cmd && (cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_POLL_OFF)
      begin
         serial_poll <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clear and trigger pulses
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         device_clear <= 1'b0;
         trigger_pulse <= 1'b0;
      end
      else
      begin
         device_clear <= is_cmd && (((cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_DEV_CLEAR)
            || (addressed_listen && (cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_SEL_CLEAR));
         trigger_pulse <= is_cmd && (addressed_listen || trigger_unaddressed)
            && ((cmd & `GBCD_BYTE_MASK) == `GBCD_CMD_TRIGGER);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // data path to parser
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         data_byte <= '0;
         data_valid <= 1'b0;
      end
      else
      begin
         data_valid <= is_data;
         if (is_data)
         begin
            data_byte.data <= cmd;
            data_byte.eoi <= mgmt.eoi;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // service request
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         srq_n_out <= 1'b0;
         srq_n_oe_n <= 1'b1;
      end
      else
      begin
         srq_n_out <= 1'b0;
         if (service_req)
         begin
            srq_n_oe_n <= 1'b0;
         end
         else if (service_done)
         begin
            srq_n_oe_n <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/gbcd_defs.svh ====
// constants for the bus command decoder
`ifndef GBCD_DEFS_SVH
`define GBCD_DEFS_SVH
`define GBCD_LISTEN_BASE 8'h20
`define GBCD_TALK_BASE 8'h40
`define GBCD_GROUP_MASK 8'h60
`define GBCD_SECONDARY_BASE 8'h60
`define GBCD_ADDR_MASK 8'h1F
`define GBCD_CMD_GO_LOCAL 8'h01
`define GBCD_CMD_SEL_CLEAR 8'h04
`define GBCD_CMD_TRIGGER 8'h08
`define GBCD_CMD_LOCKOUT 8'h11
`define GBCD_CMD_DEV_CLEAR 8'h14
`define GBCD_CMD_POLL_ON 8'h18
`define GBCD_CMD_POLL_OFF 8'h19
`define GBCD_CMD_UNLISTEN 8'h3F
`define GBCD_CMD_UNTALK 8'h5F
`define GBCD_BYTE_MASK 8'h7F
`endif

// ==== rtl/gbcd_pkg.sv ====
// types for the bus command decoder
`default_nettype none
package gbcd_pkg;
   // management lines as sensed, true = asserted
   typedef struct packed {
      logic atn;
      logic ifc;
      logic ren;
      logic eoi;
   } gbcd_mgmt_s;
   // one accepted byte
   typedef struct packed {
      logic [7:0] data;
      logic eoi;
   } gbcd_byte_s;
   typedef enum logic [1:0] {
      GBCD_HS_IDLE = 2'b00,
      GBCD_HS_TAKE = 2'b01,
      GBCD_HS_DONE = 2'b10
   } gbcd_hs_e;
endpackage
`default_nettype wire

// ==== sim/gbcd_decoder_checker.sv ====
// port assertions for the bus command decoder
`default_nettype none
module gbcd_decoder_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [4:0] primary_addr,
   input wire logic [7:0] dio_n_in,
   input wire logic atn_n_in,
   input wire logic ifc_n_in,
   input wire logic ren_n_in,
   input wire logic dav_n_in,
   input wire logic service_req,
   input wire logic ndac_n_oe_n,
   input wire logic srq_n_oe_n,
   input wire logic data_valid,
   input wire logic talker_active,
   input wire logic listener_active,
   input wire logic remote_mode,
   input wire logic lockout,
   input wire logic serial_poll
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////
   sequence s_cmd(logic [6:0] b);
      $fell(dav_n_in) && !atn_n_in && ~dio_n_in[6:0] == b;
   endsequence
   sequence s_data;
      $fell(dav_n_in) && atn_n_in && listener_active;
   endsequence
   ////////////////////////////////
   ifc_idle_a: assert property (!ifc_n_in |=> !talker_active && !listener_active)
      else $error("ifc kept address");
   ren_off_a: assert property (ren_n_in |=> !remote_mode && !lockout)
      else $error("local not restored");
   listen_adr_a: assert property (s_cmd({2'b01, primary_addr}) |-> ##2 listener_active)
      else $error("not listener");
   talk_adr_a: assert property (s_cmd({2'b10, primary_addr}) |-> ##2 talker_active)
      else $error("not talker");
   unlisten_a: assert property (s_cmd(7'h3F) |-> ##2 !listener_active)
      else $error("still listener");
   lockout_a: assert property (s_cmd(7'h11) ##0 !ren_n_in [*3] |-> lockout)
      else $error("no lockout");
   poll_on_a: assert property (s_cmd(7'h18) |-> ##2 serial_poll)
      else $error("no poll mode");
   gtl_local_a: assert property (s_cmd(7'h01) ##0 listener_active
      |-> ##2 !remote_mode ##1 !remote_mode)
      else $error("go to local undone");
   data_pass_a: assert property (s_data |-> ##2 data_valid)
      else $error("data not passed");
   srq_set_a: assert property (service_req |=> !srq_n_oe_n)
      else $error("srq not pulled");
   ndac_hold_a: assert property (dav_n_in [*3] |-> !ndac_n_oe_n)
      else $error("ndac released");
endmodule
bind gbcd_decoder gbcd_decoder_checker u_chk (.clk(clk), .reset_n(reset_n),
   .primary_addr(primary_addr), .dio_n_in(dio_n_in), .atn_n_in(atn_n_in),
   .ifc_n_in(ifc_n_in), .ren_n_in(ren_n_in), .dav_n_in(dav_n_in),
   .service_req(service_req), .ndac_n_oe_n(ndac_n_oe_n), .srq_n_oe_n(srq_n_oe_n),
   .data_valid(data_valid), .talker_active(talker_active),
   .listener_active(listener_active), .remote_mode(remote_mode), .lockout(lockout),
   .serial_poll(serial_poll));
`default_nettype wire

// ==== sim/gbcd_ctl_model.sv ====
// controller-side model: sends bytes by driving DAV and waiting only for NDAC release (NRFD unused)
`default_nettype none
module gbcd_ctl_model (
   input wire logic clk,
   input wire logic ndac_n_oe_n,
   output logic [7:0] dio_n,
   output logic atn_n,
   output logic dav_n,
   output logic eoi_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      dio_n = 8'hFF;
      atn_n = 1'b1;
      dav_n = 1'b1;
      eoi_n = 1'b1;
   end
   ////////////////////////////////
   task automatic send(input logic [7:0] b, input logic atn, input logic eoi, output logic ok);
      int n;
      @(negedge clk);
      dio_n = ~b;
      atn_n = ~atn;
      eoi_n = ~eoi;
      @(negedge clk);
      dav_n = 1'b0;
      n = 0;
      while (ndac_n_oe_n !== 1'b1 && n < 10)
      begin
         @(negedge clk);
         n++;
      end
      ok = ndac_n_oe_n;
      // released lines float to the pull-up
      dav_n = 1'b1;
      dio_n = 8'hFF;
      eoi_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ==== sim/gbcd_decoder_tb.sv ====
// self-checking bench for the bus command decoder
`default_nettype none
module gbcd_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gbcd_pkg::*;
   logic clk = 0, reset_n = 0, ifc_n = 1, ren_n = 1, srv = 0, srv_done = 0;
   logic trg_un = 0, glr = 0, ok, atn_n, dav_n, eoi_n, ndac_oe_n, srq_oe_n;
   logic dv, tk, ls, rm, lk, sp, dc, tp, rfd_oe_n;
   logic [4:0] pa = 0;
   logic [7:0] dio_n, b;
   gbcd_byte_s db, last;
   int seed = 56637, miscompares = 0, checked = 0, cyc = 0, n_dv = 0, n_dc = 0, n_tp = 0;
   always #2 clk = ~clk;
   gbcd_decoder u_gbcd_decoder (.clk(clk), .reset_n(reset_n), .primary_addr(pa),
      .trigger_unaddressed(trg_un), .lockout_released_by_local(glr), .dio_n_in(dio_n),
      .atn_n_in(atn_n), .ifc_n_in(ifc_n), .ren_n_in(ren_n), .eoi_n_in(eoi_n),
      .dav_n_in(dav_n), .service_req(srv), .service_done(srv_done), .ndac_n_out(),
      .ndac_n_oe_n(ndac_oe_n), .nrfd_n_out(), .nrfd_n_oe_n(rfd_oe_n), .srq_n_out(),
      .srq_n_oe_n(srq_oe_n), .data_byte(db), .data_valid(dv), .talker_active(tk),
      .listener_active(ls), .remote_mode(rm), .lockout(lk), .serial_poll(sp),
      .device_clear(dc), .trigger_pulse(tp));
   gbcd_ctl_model u_gbcd_ctl_model (.clk(clk), .ndac_n_oe_n(ndac_oe_n), .dio_n(dio_n),
      .atn_n(atn_n), .dav_n(dav_n), .eoi_n(eoi_n));
   ////////////////////////////////
   function automatic logic [7:0] adr(input logic [7:0] base, input logic [4:0] a);
      return base | {3'b000, a};
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      u_gbcd_ctl_model.send(c, 1'b1, 1'b0, ok);
   endtask
   task automatic close_out();
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      n_dv += (dv === 1'b1);
      n_dc += (dc === 1'b1);
      n_tp += (tp === 1'b1);
      if (dv === 1'b1)
         last = db;
      if (cyc == 3000)
      begin
         miscompares++;
         close_out();
      end
   end
   ////////////////////////////////
   initial
   begin
      pa = 5'($unsigned($random(seed)) % 30);
      repeat (6) @(negedge clk);
      reset_n = 1;
      chk("srq", 1, srq_oe_n);
      chk("rfd", 1, rfd_oe_n);
      chk("ndac", 0, ndac_oe_n);
      ren_n = 0;
      repeat (2) @(negedge clk);
      chk("rem", 1, rm);
      cmd(adr(8'h20, pa));
      chk("acc", 1, ok);
      chk("lsn", 1, ls);
      cmd(adr(8'h40, pa));
      chk("tlk", 1, tk);
      cmd(adr(8'h40, pa + 5'd1));
      chk("tlk", 0, tk);
      for (int i = 0; i < 3; i++)
      begin
         b = 8'($random(seed));
         u_gbcd_ctl_model.send(b, 1'b0, i == 2, ok);
         chk("dat", b, last.data);
      end
      chk("eoi", 1, last.eoi);
      cmd(8'h08);
      chk("trg", 1, n_tp);
      cmd(8'h11);
      chk("llo", 1, lk);
      glr = 1;
      cmd(8'h01);
      chk("llo", 0, lk);
      chk("rem", 0, rm);
      cmd(8'h04);
      chk("clr", 1, n_dc);
      cmd(8'h3F);
      chk("lsn", 0, ls);
      cmd(adr(8'h60, pa));
      chk("lsn", 0, ls);
      cmd(8'h04);
      cmd(8'h08);
      chk("clr", 1, n_dc);
      chk("trg", 1, n_tp);
      trg_un = 1;
      cmd(8'h08);
      chk("trg", 2, n_tp);
      cmd(8'h14);
      chk("clr", 2, n_dc);
      u_gbcd_ctl_model.send(8'hA5, 1'b0, 1'b0, ok);
      chk("ref", 0, ok);
      chk("ndv", 3, n_dv);
      cmd(8'h18);
      chk("spl", 1, sp);
      cmd(8'h19);
      chk("spl", 0, sp);
      cmd(adr(8'h40, pa));
      cmd(8'h5F);
      chk("tlk", 0, tk);
      cmd(adr(8'h20, pa));
      cmd(adr(8'h40, pa));
      chk("rem", 1, rm);
      ifc_n = 0;
      repeat (2) @(negedge clk);
      ifc_n = 1;
      chk("ifc", 0, tk | ls);
      srv = 1;
      @(negedge clk);
      srv = 0;
      repeat (4) @(negedge clk);
      chk("srq", 0, srq_oe_n);
      srv_done = 1;
      @(negedge clk);
      srv_done = 0;
      @(negedge clk);
      chk("srq", 1, srq_oe_n);
      ren_n = 1;
      repeat (2) @(negedge clk);
      chk("rem", 0, rm);
      close_out();
   end
endmodule
`default_nettype wire
